// ===== design/cmr_array.sv
// Macrocell array: four groups of configurable register cells
// Functional notes
// R1: Fixed D setting ignores select.
// R2: Fixed T setting toggles, ignores select.
// R3: Fixed JK setting ignores select.
// R4: D-to-T dual: select false D, true T.
// R5: D-to-JK dual: select false D, true JK.
// R6: T-to-D dual: select false T, true D.
// R7: Shared select, changeable during normal operation.
// R8: Four groups A-D of five, six or three.
// R9: JK-to-D dual: select false JK, true D.
`timescale 1ns/1ps
module cmr_array #(
  parameter int unsigned DEPTH = cmr_pkg::CMR_DEPTH_5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [cmr_pkg::CMR_MAX_CELLS-1:0] cell_en,
  input wire logic [cmr_pkg::CMR_MAX_CELLS-1:0] cell_d,
  input wire logic [cmr_pkg::CMR_MAX_CELLS-1:0] cell_k,
  output logic [cmr_pkg::CMR_MAX_CELLS-1:0] cell_q
);
  localparam int unsigned NCELL = cmr_pkg::CMR_GROUPS * DEPTH;
  localparam int unsigned MW = cmr_pkg::CMR_MODES_PER_WORD;
  localparam int unsigned FW = cmr_pkg::CMR_MODE_FIELD;

  logic wr_stb;
  logic rd_stb;
  logic [7:0] addr;
  logic sel_r;
  logic sel_nxt;
  logic [cmr_pkg::CMR_MODE_W-1:0] mode_r [cmr_pkg::CMR_MAX_CELLS];
  logic [cmr_pkg::CMR_MODE_W-1:0] mode_nxt [cmr_pkg::CMR_MAX_CELLS];
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] mode_word [3];

  // Group depth must be one of the array variants
  initial begin
    depth_ok_a: assert (DEPTH == cmr_pkg::CMR_DEPTH_5 ||
      DEPTH == cmr_pkg::CMR_DEPTH_6 || DEPTH == cmr_pkg::CMR_DEPTH_3)
      else $error("unsupported group depth"); // [R8]
  end

  cmr_ahb u_ahb (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr)
  );

  // Select bit and per-cell settings written by software
  always_comb begin
    sel_nxt = sel_r;
    for (int i = 0; i < cmr_pkg::CMR_MAX_CELLS; i++) begin
      mode_nxt[i] = mode_r[i];
    end
    if (wr_stb) begin
      if (addr == cmr_pkg::CMR_OFS_CTRL) begin
        sel_nxt = hwdata[cmr_pkg::CMR_CTRL_SEL_BIT]; // [R7]
      end
      for (int i = 0; i < cmr_pkg::CMR_MAX_CELLS; i++) begin
        if (addr == cmr_pkg::CMR_OFS_MODE0 + 8'((i / MW) * 4)) begin
          mode_nxt[i] = hwdata[(i % MW) * FW +: cmr_pkg::CMR_MODE_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_r <= 1'b0;
      for (int i = 0; i < cmr_pkg::CMR_MAX_CELLS; i++) begin
        mode_r[i] <= cmr_pkg::CMR_MODE_RST;
      end
    end else begin
      sel_r <= sel_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Pack settings into readable words
  always_comb begin
    for (int w = 0; w < 3; w++) begin
      mode_word[w] = cmr_pkg::CMR_WORD_ZERO;
    end
    for (int i = 0; i < cmr_pkg::CMR_MAX_CELLS; i++) begin
      mode_word[i / MW][(i % MW) * FW +: cmr_pkg::CMR_MODE_W] = mode_r[i];
    end
  end

  // Read mux on the live address, registered for the data phase
  always_comb begin
    rdata_nxt = cmr_pkg::CMR_WORD_ZERO;
    unique case (haddr[7:0])
      cmr_pkg::CMR_OFS_CTRL: rdata_nxt[cmr_pkg::CMR_CTRL_SEL_BIT] = sel_r;
      cmr_pkg::CMR_OFS_STATE: rdata_nxt[cmr_pkg::CMR_MAX_CELLS-1:0] = cell_q;
      cmr_pkg::CMR_OFS_INFO: rdata_nxt = 32'(DEPTH);
      cmr_pkg::CMR_OFS_MODE0: rdata_nxt = mode_word[0];
      cmr_pkg::CMR_OFS_MODE1: rdata_nxt = mode_word[1];
      cmr_pkg::CMR_OFS_MODE2: rdata_nxt = mode_word[2];
      default: rdata_nxt = cmr_pkg::CMR_WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= cmr_pkg::CMR_WORD_ZERO;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read path uses the live address phase
  assign hrdata = rdata_r;

  // Cells: groups A..D, DEPTH cells each, index = group*DEPTH+row
  for (genvar c = 0; c < cmr_pkg::CMR_MAX_CELLS; c++) begin : g_cell
    if (c < NCELL) begin : g_used
      cmr_cell u_cell (
        .clk(clk),
        .rst(rst),
        .mode(cmr_pkg::cmr_mode_t'(mode_r[c])),
        .register_type_select(sel_r), // [R7]
        .en(cell_en[c]),
        .d_in(cell_d[c]),
        .k_in(cell_k[c]),
        .q(cell_q[c])
      ); // [R8]
    end else begin : g_unused
      assign cell_q[c] = 1'b0;
    end
  end

  sel_live_a: assert property (@(posedge clk) disable iff (rst)
    wr_stb && addr == cmr_pkg::CMR_OFS_CTRL
    |=> sel_r == $past(hwdata[cmr_pkg::CMR_CTRL_SEL_BIT]))
    else $error("select not updated"); // [R7]
  unused_low_a: assert property (@(posedge clk)
    NCELL == cmr_pkg::CMR_MAX_CELLS || cell_q[cmr_pkg::CMR_MAX_CELLS-1] == 1'b0)
    else $error("absent cell drives output"); // [R8]
  unused_rd_a: assert property (@(posedge clk) disable iff (rst)
    rd_stb && addr == cmr_pkg::CMR_OFS_INFO |-> hrdata == 32'(DEPTH))
    else $error("info word read wrong"); // [R8]
endmodule : cmr_array

// ===== design/cmr_pkg.sv
// Package: mode codes, register map and widths for the macrocell array
package cmr_pkg;
  // Register type setting of one cell
  typedef enum logic [2:0] {
    CMR_FF_D,
    CMR_FF_T,
    CMR_FF_JK,
    CMR_D_TO_TOGGLE_DUAL,
    CMR_D_TO_JK_DUAL,
    CMR_TOGGLE_TO_D_DUAL,
    CMR_JK_TO_D_DUAL
  } cmr_mode_t;

  // Effective flip-flop behaviour
  typedef enum logic [1:0] {
    CMR_ACT_D,
    CMR_ACT_T,
    CMR_ACT_JK
  } cmr_act_t;

  localparam int unsigned CMR_GROUPS = 4;
  localparam int unsigned CMR_DEPTH_5 = 5;
  localparam int unsigned CMR_DEPTH_6 = 6;
  localparam int unsigned CMR_DEPTH_3 = 3;
  localparam int unsigned CMR_MAX_CELLS = CMR_GROUPS * CMR_DEPTH_6;
  localparam int unsigned CMR_MODE_W = 3;

  // Byte offsets of the register map
  localparam logic [7:0] CMR_OFS_CTRL = 8'h00;
  localparam logic [7:0] CMR_OFS_STATE = 8'h04;
  localparam logic [7:0] CMR_OFS_INFO = 8'h08;
  localparam logic [7:0] CMR_OFS_MODE0 = 8'h10;
  localparam logic [7:0] CMR_OFS_MODE1 = 8'h14;
  localparam logic [7:0] CMR_OFS_MODE2 = 8'h18;
  localparam int unsigned CMR_MODES_PER_WORD = 8;
  localparam int unsigned CMR_MODE_FIELD = 4;
  localparam int unsigned CMR_CTRL_SEL_BIT = 0;
  localparam logic [2:0] CMR_MODE_RST = 3'h0;
  localparam logic [31:0] CMR_WORD_ZERO = 32'h0000_0000;
endpackage : cmr_pkg

// ===== design/cmr_cell.sv
// One logic cell: register whose type follows setting and select
`timescale 1ns/1ps
module cmr_cell (
  input wire logic clk,
  input wire logic rst,
  input wire cmr_pkg::cmr_mode_t mode,
  input wire logic register_type_select,
  input wire logic en,
  input wire logic d_in,
  input wire logic k_in,
  output logic q
);
  cmr_pkg::cmr_act_t act;
  logic q_r;
  logic q_nxt;

  // Pick the behaviour from setting and select
  always_comb begin
    unique case (mode)
      cmr_pkg::CMR_FF_D: act = cmr_pkg::CMR_ACT_D; // [R1]
      cmr_pkg::CMR_FF_T: act = cmr_pkg::CMR_ACT_T; // [R2]
      cmr_pkg::CMR_FF_JK: act = cmr_pkg::CMR_ACT_JK; // [R3]
      cmr_pkg::CMR_D_TO_TOGGLE_DUAL: act = register_type_select ?
          cmr_pkg::CMR_ACT_T : cmr_pkg::CMR_ACT_D; // [R4]
      cmr_pkg::CMR_D_TO_JK_DUAL: act = register_type_select ?
          cmr_pkg::CMR_ACT_JK : cmr_pkg::CMR_ACT_D; // [R5]
      cmr_pkg::CMR_TOGGLE_TO_D_DUAL: act = register_type_select ?
          cmr_pkg::CMR_ACT_D : cmr_pkg::CMR_ACT_T; // [R6]
      cmr_pkg::CMR_JK_TO_D_DUAL: act = register_type_select ?
          cmr_pkg::CMR_ACT_D : cmr_pkg::CMR_ACT_JK; // [R9]
      default: act = cmr_pkg::CMR_ACT_D;
    endcase
  end

  // Next state: d_in is D, T or J; k_in is K
  always_comb begin
    q_nxt = q_r;
    if (en) begin
      unique case (act)
        cmr_pkg::CMR_ACT_D: q_nxt = d_in;
        cmr_pkg::CMR_ACT_T: q_nxt = q_r ^ d_in;
        cmr_pkg::CMR_ACT_JK: q_nxt = (d_in & ~q_r) | (~k_in & q_r);
        default: q_nxt = q_r;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

  d_mode_a: assert property (@(posedge clk) disable iff (rst)
    en && act == cmr_pkg::CMR_ACT_D |=> q_r == $past(d_in))
    else $error("d behaviour wrong"); // [R1]
  t_mode_a: assert property (@(posedge clk) disable iff (rst)
    en && act == cmr_pkg::CMR_ACT_T && d_in |=> q_r != $past(q_r))
    else $error("toggle behaviour wrong"); // [R2]
  jk_mode_a: assert property (@(posedge clk) disable iff (rst)
    en && act == cmr_pkg::CMR_ACT_JK && !d_in && !k_in
    |=> $stable(q_r))
    else $error("jk hold wrong"); // [R3]
  dt_sel_a: assert property (@(posedge clk)
    mode == cmr_pkg::CMR_D_TO_TOGGLE_DUAL && register_type_select
    |-> act == cmr_pkg::CMR_ACT_T)
    else $error("d to t select wrong"); // [R4]
  djk_sel_a: assert property (@(posedge clk)
    mode == cmr_pkg::CMR_D_TO_JK_DUAL
    |-> act == (register_type_select ? cmr_pkg::CMR_ACT_JK
        : cmr_pkg::CMR_ACT_D))
    else $error("d to jk select wrong"); // [R5]
  td_sel_a: assert property (@(posedge clk)
    mode == cmr_pkg::CMR_TOGGLE_TO_D_DUAL && !register_type_select
    |-> act == cmr_pkg::CMR_ACT_T)
    else $error("t to d select wrong"); // [R6]
  jkd_sel_a: assert property (@(posedge clk)
    mode == cmr_pkg::CMR_JK_TO_D_DUAL
    |-> act == (register_type_select ? cmr_pkg::CMR_ACT_D
        : cmr_pkg::CMR_ACT_JK))
    else $error("jk to d select wrong"); // [R9]
  hold_idle_a: assert property (@(posedge clk) disable iff (rst)
    !en |=> $stable(q_r))
    else $error("cell changed while idle");
endmodule : cmr_cell

// ===== design/cmr_ahb.sv
// AHB-Lite slave front end: address capture and strobes
`timescale 1ns/1ps
module cmr_ahb (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] addr
);
  logic wr_r;
  logic wr_nxt;
  logic rd_r;
  logic rd_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic take;

  // Capture a valid address phase
  always_comb begin
    take = hsel && hready && htrans[1];
    wr_nxt = take && hwrite;
    rd_nxt = take && !hwrite;
    addr_nxt = take ? haddr[7:0] : addr_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_stb = wr_r;
  assign rd_stb = rd_r;
  assign addr = addr_r;

  strobe_once_a: assert property (@(posedge clk) disable iff (rst)
    hsel && hready && htrans[1] && hwrite |=> wr_stb && !rd_stb)
    else $error("write strobe missing");
  unused_size_a: assert property (@(posedge clk) disable iff (rst)
    hsel && htrans[1] |-> hsize <= 3'h2)
    else $error("transfer wider than a word");
endmodule : cmr_ahb

// ===== dv/test_configurable_macrocell_register.sv
// Self-checking bench for the configurable macrocell array
`timescale 1ns/1ps
module test_configurable_macrocell_register;
  localparam int unsigned DEPTH = cmr_pkg::CMR_DEPTH_5;
  localparam int unsigned NC = cmr_pkg::CMR_GROUPS * DEPTH;
  localparam int unsigned MW = cmr_pkg::CMR_MAX_CELLS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [MW-1:0] cell_en = '0;
  logic [MW-1:0] cell_d = '0;
  logic [MW-1:0] cell_k = '0;
  logic [MW-1:0] cell_q;
  logic [MW-1:0] mq = '0;
  int mode_m[MW];
  int sel_m;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [31:0] wd;

  // Clock and single-slave ready loop
  always #2.5 clk = ~clk;
  assign hready = hreadyout;

  cmr_array #(.DEPTH(DEPTH)) i_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cell_en(cell_en), .cell_d(cell_d), .cell_k(cell_k), .cell_q(cell_q)
  );

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer, waits on hready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h00_0000, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer

  // Reference next state of one cell
  function automatic logic nxt(int m, int s, logic q, logic j, logic k);
    int act;
    case (m)
      1: act = 1;
      2: act = 2;
      3: act = s ? 1 : 0;
      4: act = s ? 2 : 0;
      5: act = s ? 0 : 1;
      6: act = s ? 0 : 2;
      default: act = 0;
    endcase
    if (act == 1) return q ^ j;
    if (act == 2) return (j & ~q) | (~k & q);
    return j;
  endfunction : nxt

  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h63a5));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values, info word and two unmapped addresses
    xfer(1'b0, cmr_pkg::CMR_OFS_INFO, 32'h0, rd);
    chk(rd, DEPTH);
    for (int a = 0; a < 32; a += 4) begin
      if (a != 8) begin
        xfer(1'b0, 8'(a), 32'h0, rd);
        chk(rd, 32'h0000_0000);
      end
    end
    $display("test reset values done");
    for (int r = 0; r < 8; r++) begin
      // New settings on even rounds; select 0 on even rounds, 1 on odd ones
      if (r % 2 == 0) begin
        for (int i = 0; i < MW; i++) begin
          mode_m[i] = (i >= NC) ? 0 : (r == 0) ? i % 7 : $urandom % 8;
        end
        for (int w = 0; w < 3; w++) begin
          wd = 32'h0;
          for (int b = 0; b < 8; b++) wd[b*4 +: 4] = 4'(mode_m[w*8 + b]);
          xfer(1'b1, 8'(16 + 4 * w), wd, rd);
          xfer(1'b0, 8'(16 + 4 * w), 32'h0, rd);
          chk(rd, wd);
        end
      end
      sel_m = r % 2;
      xfer(1'b1, cmr_pkg::CMR_OFS_CTRL, 32'(sel_m), rd);
      xfer(1'b0, cmr_pkg::CMR_OFS_CTRL, 32'h0, rd);
      chk(rd, 32'(sel_m));
      // Random cell traffic against the reference
      for (int s = 0; s < 40; s++) begin
        @(posedge clk);
        for (int i = 0; i < NC; i++) begin
          if (cell_en[i]) mq[i] = nxt(mode_m[i], sel_m, mq[i], cell_d[i],
                                      cell_k[i]);
        end
        cell_en <= (s < 39) ? MW'($urandom) : '0;
        cell_d <= MW'($urandom);
        cell_k <= MW'($urandom);
        #1;
        chk(32'(cell_q), 32'(mq));
      end
      xfer(1'b0, cmr_pkg::CMR_OFS_STATE, 32'h0, rd);
      chk(rd, 32'(mq));
      $display("test round %0d done", r);
    end
    report_and_stop();
  end
endmodule : test_configurable_macrocell_register
